// ===== ch13_16_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// register and line checks
// ****************************************
module ch13_16_checker #(
   parameter int WIDTH = 14
) (
   // bus side
   input wire logic             clk_i,
   input wire logic             srst_i,
   input wire logic [7:0]       addr_i,
   input wire logic [15:0]      wdata_i,
   input wire logic             wr_i,
   input wire logic             rd_i,
   input wire logic [15:0]      rdata_o,
   // line side
   input wire logic             per_line_pattern_enable_i,
   input wire logic [WIDTH-1:0] sample_i [4],
   input wire logic [WIDTH-1:0] pattern_data_i [4],
   input wire logic [WIDTH-1:0] line_data_o [4],
   // controls
   input wire logic [2:0]       line15_pattern_code_o,
   input wire logic [2:0]       line16_pattern_code_o,
   input wire logic [3:0]       digital_powerdown_o,
   input wire logic [3:0]       driver_powerdown_o,
   input wire logic [3:0]       analog_powerdown_o,
   input wire logic [3:0]       data_flip_o,
   input wire logic [3:0]       out_clock_delay_steps_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   wire w3b = wr_i && addr_i == 8'h3B;
   wire on3 = !wr_i && !driver_powerdown_o[3] && !digital_powerdown_o[3];
   property p_l15; w3b |=> line15_pattern_code_o == $past(wdata_i[7:5]); endproperty
   a_l15: assert property (p_l15) else $error("line 15 code wrong");
   property p_l16; w3b |=> line16_pattern_code_o == $past(wdata_i[4:2]); endproperty
   a_l16: assert property (p_l16) else $error("line 16 code wrong");
   property p_pi; wr_i && addr_i == 8'h3C |=> {digital_powerdown_o, driver_powerdown_o,
      analog_powerdown_o, data_flip_o} == $past(wdata_i); endproperty
   a_pi: assert property (p_pi) else $error("power or flip field wrong");
   property p_dly; wr_i && addr_i == 8'h43 |=> out_clock_delay_steps_o == $past(wdata_i[4:1]);
   endproperty
   a_dly: assert property (p_dly) else $error("clock delay wrong");
   property p_rd; rd_i && addr_i == 8'h3C |=> rdata_o == {digital_powerdown_o,
      driver_powerdown_o, analog_powerdown_o, data_flip_o}; endproperty
   a_rd: assert property (p_rd) else $error("read back wrong");
   property p_rdp; rd_i && addr_i == 8'h3B |=> rdata_o[7:2] == {line15_pattern_code_o,
      line16_pattern_code_o}; endproperty
   a_rdp: assert property (p_rdp) else $error("pattern read wrong");
   property p_pdn; driver_powerdown_o[2] && !wr_i |=> line_data_o[2] == '0; endproperty
   a_pdn: assert property (p_pdn) else $error("line not off");
   property p_inv; on3 && data_flip_o[3] && line16_pattern_code_o == 3'h0
      |=> line_data_o[3] == ~$past(sample_i[3]); endproperty
   a_inv: assert property (p_inv) else $error("line not inverted");
   property p_pat; on3 && per_line_pattern_enable_i && line16_pattern_code_o != 3'h0
      |=> line_data_o[3] == $past(pattern_data_i[3]); endproperty
   a_pat: assert property (p_pat) else $error("pattern altered");
endmodule
bind ch13_16_output_ctrl ch13_16_checker #(.WIDTH(WIDTH)) u_chk (.clk_i(clk_i),
   .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .per_line_pattern_enable_i(per_line_pattern_enable_i),
   .sample_i(sample_i), .pattern_data_i(pattern_data_i), .line_data_o(line_data_o),
   .line15_pattern_code_o(line15_pattern_code_o),
   .line16_pattern_code_o(line16_pattern_code_o),
   .digital_powerdown_o(digital_powerdown_o), .driver_powerdown_o(driver_powerdown_o),
   .analog_powerdown_o(analog_powerdown_o), .data_flip_o(data_flip_o),
   .out_clock_delay_steps_o(out_clock_delay_steps_o));
`default_nettype wire

// ===== ch13_16_output_ctrl.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ch13_16_regs.svh"

module ch13_16_output_ctrl #(
   parameter int WIDTH = 14
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // register port
   input  wire logic [7:0]       addr_i,
   input  wire logic [15:0]      wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [15:0]      rdata_o,
   // pattern steering from elsewhere
   input  wire logic             per_line_pattern_enable_i,
   input  wire logic [1:0]       line13_14_pattern_active_i,
   // per line data, index 0 is line 13
   input  wire logic [WIDTH-1:0] sample_i [4],
   input  wire logic [WIDTH-1:0] pattern_data_i [4],
   output logic      [WIDTH-1:0] line_data_o [4],
   // control outputs, index 0 is channel 13
   output logic      [2:0]       line15_pattern_code_o,
   output logic      [2:0]       line16_pattern_code_o,
   output logic      [3:0]       digital_powerdown_o,
   output logic      [3:0]       driver_powerdown_o,
   output logic      [3:0]       analog_powerdown_o,
   output logic      [3:0]       data_flip_o,
   output logic      [3:0]       out_clock_delay_steps_o
);

   // ****************************************
   // local types
   // ****************************************
   // one flag per mapped register, all clear for an unmapped address
   typedef struct packed {
      logic pattern;
      logic power;
      logic delay;
   } reg_hit_t;

   ch13_16_pkg::ctrl_state_t state;
   ch13_16_pkg::ctrl_state_t next_state;
   reg_hit_t                 hit;
   logic [3:0]               pattern_active;
   logic [3:0]               line_off;

   // ****************************************
   // helper functions
   // ****************************************
   // shared by write and read so both paths agree on the map
   function automatic reg_hit_t reg_hit(input logic [7:0] addr);
      reg_hit_t flags;
      flags = '0;
      case (addr)
         `PATTERN_SELECT_ADDR: begin
            flags.pattern = 1'b1;
         end
         `POWER_INVERT_ADDR: begin
            flags.power = 1'b1;
         end
         `CLOCK_DELAY_ADDR: begin
            flags.delay = 1'b1;
         end
         default: begin
            flags = '0;
         end
      endcase
      return flags;
   endfunction

   function automatic logic [15:0] read_word(
      input reg_hit_t                 flags,
      input ch13_16_pkg::ctrl_state_t regs
   );
      logic [15:0] word;
      word = `UNMAPPED_READ;
      if (flags.pattern) begin
         word = regs.pattern_select;
      end
      if (flags.power) begin
         word = regs.power_invert;
      end
      if (flags.delay) begin
         word = regs.clock_delay;
      end
      return word;
   endfunction

   // full words stored so reserved bits read back what was written
   function automatic ch13_16_pkg::ctrl_state_t write_word(
      input ch13_16_pkg::ctrl_state_t regs,
      input reg_hit_t                 flags,
      input logic [15:0]              data
   );
      ch13_16_pkg::ctrl_state_t result;
      result = regs;
      if (flags.pattern) begin
         result.pattern_select = data;
      end
      if (flags.power) begin
         result.power_invert = data;
      end
      if (flags.delay) begin
         result.clock_delay = data;
      end
      return result;
   endfunction

   // code zero keeps the line on sample data even with per-line selection on
   function automatic logic line_uses_pattern(
      input logic       enable,
      input logic [2:0] code
   );
      return enable && (code != `PAT_CODE_NORMAL);
   endfunction

   // driver or whole digital block down leaves the line silent
   function automatic logic line_is_off(
      input logic driver_down,
      input logic digital_down
   );
      return driver_down | digital_down;
   endfunction

   // ****************************************
   // register access
   // ****************************************
   assign hit = reg_hit(addr_i);

   always_comb begin
      next_state = state;
      // unmapped writes hit nothing and change nothing
      if (wr_i) begin
         next_state = write_word(state, hit, wdata_i);
      end
      if (rd_i) begin
         next_state.rdata = read_word(hit, state);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state.pattern_select <= `CTRL_RESET;
         state.power_invert   <= `CTRL_RESET;
         state.clock_delay    <= `CTRL_RESET;
         state.rdata          <= `UNMAPPED_READ;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // control outputs
   // ****************************************
   assign rdata_o                 = state.rdata;
   assign line15_pattern_code_o   = state.pattern_select[`LINE15_PAT_HI:`LINE15_PAT_LO];
   assign line16_pattern_code_o   = state.pattern_select[`LINE16_PAT_HI:`LINE16_PAT_LO];
   assign digital_powerdown_o     = state.power_invert[`DIG_PDN_HI:`DIG_PDN_LO];
   assign driver_powerdown_o      = state.power_invert[`DRV_PDN_HI:`DRV_PDN_LO];
   // analog blocks sit outside this logic: these bits only leave as outputs
   // analog powerdown
   assign analog_powerdown_o      = state.power_invert[`ANA_PDN_HI:`ANA_PDN_LO];
   assign data_flip_o             = state.power_invert[`FLIP_HI:`FLIP_LO];
   assign out_clock_delay_steps_o = state.clock_delay[`CLK_DELAY_HI:`CLK_DELAY_LO];

   // ****************************************
   // line output stages
   // ****************************************
   // silent lines
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         line_off[i] = line_is_off(driver_powerdown_o[i], digital_powerdown_o[i]);
      end
   end

   always_comb begin
      // lines 13 and 14 take their pattern decision from outside
      pattern_active[1:0] = line13_14_pattern_active_i;
      pattern_active[2]   = line_uses_pattern(per_line_pattern_enable_i,
                                              line15_pattern_code_o);
      pattern_active[3]   = line_uses_pattern(per_line_pattern_enable_i,
                                              line16_pattern_code_o);
   end

   for (genvar i = 0; i < 4; i++) begin : g_line
      line_output_stage #(
         .WIDTH (WIDTH)
      ) u_stage (
         .clk_i            (clk_i),
         .srst_i           (srst_i),
         .sample_i         (sample_i[i]),
         .pattern_data_i   (pattern_data_i[i]),
         .pattern_active_i (pattern_active[i]),
         .flip_i           (data_flip_o[i]),
         .powerdown_i      (line_off[i]),
         .data_o           (line_data_o[i])
      );
   end

endmodule

`default_nettype wire

// ===== ch13_16_output_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ch13_16_output_ctrl_tb;
   logic        clk_i, srst_i, wr_i, rd_i, per_line_pattern_enable_i;
   logic [7:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, s3b, s3c, s43;
   logic [1:0]  act;
   logic [13:0] sample_i [4], pattern_data_i [4], line_data_o [4];
   logic [2:0]  c15, c16;
   logic [3:0]  dig, drv, ana, flp, dly;
   int          failures, comparisons, cycles;
   // ****************************************
   // rows: address, write data, read back
   // ****************************************
   logic [39:0] rows [9] = '{{8'h3B, 16'h00E0, 16'h00E0}, {8'h3B, 16'h001C, 16'h001C},
      {8'h3C, 16'hF000, 16'hF000}, {8'h3C, 16'h0F00, 16'h0F00}, {8'h3C, 16'h00F0, 16'h00F0},
      {8'h3C, 16'h000F, 16'h000F}, {8'h43, 16'h001E, 16'h001E}, {8'h43, 16'h0002, 16'h0002},
      {8'h3D, 16'hFFFF, 16'h0000}};
   ch13_16_output_ctrl #(.WIDTH(14)) DUT (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .per_line_pattern_enable_i(per_line_pattern_enable_i),
      .line13_14_pattern_active_i(act), .sample_i(sample_i), .pattern_data_i(pattern_data_i),
      .line_data_o(line_data_o), .line15_pattern_code_o(c15), .line16_pattern_code_o(c16),
      .digital_powerdown_o(dig), .driver_powerdown_o(drv), .analog_powerdown_o(ana),
      .data_flip_o(flp), .out_clock_delay_steps_o(dly));
   initial begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1;
      @(posedge clk_i);
      wr_i <= 0; #1;
      if (a == 8'h3B) s3b = d;
      if (a == 8'h3C) s3c = d;
      if (a == 8'h43) s43 = d;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1;
      @(posedge clk_i);
      rd_i <= 0; #1;
      `CHK("rdata", e, rdata_o)
   endtask
   task ln(input logic [13:0] e);
      repeat (2) @(posedge clk_i);
      #1;
      foreach (line_data_o[k]) `CHK("line", e, line_data_o[k])
   endtask
   task conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // budget of cycles well above the sequence length
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin failures++; conclude(); end
   end
   initial begin
      {srst_i, wr_i, rd_i, per_line_pattern_enable_i, act, addr_i, wdata_i} = 1'b1 << 29;
      {s3b, s3c, s43} = '0;
      foreach (sample_i[k]) begin sample_i[k] = 14'h0001; pattern_data_i[k] = 14'h2AAA; end
      repeat (6) @(posedge clk_i);
      srst_i <= 0;
      #1 `CHK("reset", 26'h0, {c15, c16, dig, drv, ana, flp, dly})
      rd(8'h3B, 16'h0000); rd(8'h3C, 16'h0000); rd(8'h43, 16'h0000);
      // reserved bits always written as zero
      foreach (rows[i]) begin
         wr(rows[i][39:32], rows[i][31:16]);
         `CHK("ctrl", {s3b[7:2], s3c, s43[4:1]}, {c15, c16, dig, drv, ana, flp, dly})
         rd(rows[i][39:32], rows[i][15:0]);
      end
      wr(8'h3B, 16'h0000);
      ln(14'h3FFE);
      @(posedge clk_i);
      act <= 2'b11; per_line_pattern_enable_i <= 1;
      wr(8'h3B, 16'h00FC);
      ln(14'h2AAA);
      wr(8'h3C, 16'h0F0F);
      ln(14'h0000);
      wr(8'h3C, 16'h000F);
      wr(8'h3C, 16'hF00F);
      ln(14'h0000);
      wr(8'h3C, 16'h0000);
      ln(14'h2AAA);
      @(posedge clk_i);
      srst_i <= 1;
      repeat (2) @(posedge clk_i);
      srst_i <= 0;
      #1 `CHK("reset2", 26'h0, {c15, c16, dig, drv, ana, flp, dly})
      `CHK("reset2 line", 14'h0, line_data_o[2])
      conclude();
   end
endmodule
`default_nettype wire

// ===== ch13_16_pkg.sv
`default_nettype none
package ch13_16_pkg;

   typedef struct packed {
      logic [15:0] pattern_select;
      logic [15:0] power_invert;
      logic [15:0] clock_delay;
      logic [15:0] rdata;
   } ctrl_state_t;

endpackage
`default_nettype wire

// ===== ch13_16_regs.svh
`ifndef CH13_16_REGS_SVH
`define CH13_16_REGS_SVH

// ****************************************
// register addresses
// ****************************************
`define PATTERN_SELECT_ADDR  8'h3B
`define POWER_INVERT_ADDR    8'h3C
`define CLOCK_DELAY_ADDR     8'h43

// ****************************************
// reset and read values
// ****************************************
`define CTRL_RESET           16'h0000
`define UNMAPPED_READ        16'h0000

// ****************************************
// field positions
// ****************************************
`define LINE15_PAT_HI        7
`define LINE15_PAT_LO        5
`define LINE16_PAT_HI        4
`define LINE16_PAT_LO        2
`define DIG_PDN_HI           15
`define DIG_PDN_LO           12
`define DRV_PDN_HI           11
`define DRV_PDN_LO           8
`define ANA_PDN_HI           7
`define ANA_PDN_LO           4
`define FLIP_HI              3
`define FLIP_LO              0
`define CLK_DELAY_HI         4
`define CLK_DELAY_LO         1
`define PAT_CODE_NORMAL      3'h0

`endif

// ===== line_output_stage.sv
`timescale 1ns/1ps
`default_nettype none

module line_output_stage #(
   parameter int WIDTH = 14
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // data sources
   input  wire logic [WIDTH-1:0] sample_i,
   input  wire logic [WIDTH-1:0] pattern_data_i,
   // controls
   input  wire logic             pattern_active_i,
   input  wire logic             flip_i,
   input  wire logic             powerdown_i,
   // serialiser side
   output logic      [WIDTH-1:0] data_o
);

   typedef struct packed {
      logic [WIDTH-1:0] data;
   } line_state_t;

   line_state_t state;
   line_state_t next_state;

   always_comb begin
      next_state = state;
      if (powerdown_i) begin
         next_state.data = '0;
      end else if (pattern_active_i) begin
         next_state.data = pattern_data_i;
      end else if (flip_i) begin
         next_state.data = ~sample_i;
      end else begin
         next_state.data = sample_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign data_o = state.data;

endmodule

`default_nettype wire
